// File: rtl/spb_pkg.sv
// Shared constants for the segmented packet bus host controller
package spb_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int SEGS  = 4;
  localparam int SEG_W = 128;
  localparam int MTY_W = 4;
  localparam int BYTE_W = 8;

  // ==========================================================================
  // Buffering and backpressure
  localparam int BUF_DEPTH      = 2;
  localparam int BP_WRITE_LIMIT = 4;

  // ==========================================================================
  // Reset values and codes
  localparam logic [MTY_W-1:0] MTY_NONE = 4'h0;

  // ==========================================================================
  // Transmit run state
  typedef enum logic {
    SPB_RUN,
    SPB_HALT
  } spb_tx_state_t;

endpackage

// File: rtl/spb_host.sv
// Host controller driving the transmit side and taking the receive side of the segmented packet bus
`timescale 1ns/1ps
`default_nettype none

// Function
// - Drive every TX valid defined each cycle
// - Start and end together only without gaps
// - First byte sits on segment top bits
// - Non-final valid segments carry full data
// - Empty count zero except on packet end
// - Empty count N blanks N low lanes
// - At most four writes after ready drops
// - Ready shared; no valid while honouring it
// - No idle cycles inside packet without backpressure; host idles and flags usr_tx_gap when its buffer runs dry mid-packet
// - Segment zero active in every data cycle
// - Active segments contiguous from segment zero
// - Segments after end may stay idle
// - Host accepts receive data every valid cycle
// - After overflow stop writing until reset
module spb_host
  import spb_pkg::*;
#(
  parameter int SEGS  = spb_pkg::SEGS,
  parameter int SEG_W = spb_pkg::SEG_W,
  parameter int DEPTH = spb_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  sys_rst,
  // User transmit beats
  input  wire logic                                  usr_tx_valid,
  output logic                                       usr_tx_ready,
  input  wire logic [SEGS-1:0][SEG_W-1:0]            usr_tx_data,
  input  wire logic [SEGS-1:0]                       usr_tx_ena,
  input  wire logic [SEGS-1:0]                       usr_tx_sop,
  input  wire logic [SEGS-1:0]                       usr_tx_eop,
  input  wire logic [SEGS-1:0]                       usr_tx_err,
  input  wire logic [SEGS-1:0][spb_pkg::MTY_W-1:0]   usr_tx_mty,
  // User transmit status
  output logic                                       usr_tx_drop,
  output logic                                       usr_tx_gap,
  output logic                                       usr_tx_halted,
  // Device transmit pins
  output logic [SEGS-1:0][SEG_W-1:0]                 tx_data,
  output logic [SEGS-1:0]                            tx_ena,
  output logic [SEGS-1:0]                            tx_sop,
  output logic [SEGS-1:0]                            tx_eop,
  output logic [SEGS-1:0]                            tx_err,
  output logic [SEGS-1:0][spb_pkg::MTY_W-1:0]        tx_mty,
  input  wire logic                                  tx_ready,
  input  wire logic                                  tx_ovf,
  // Device receive pins
  input  wire logic [SEGS-1:0][SEG_W-1:0]            rx_data,
  input  wire logic [SEGS-1:0]                       rx_ena,
  input  wire logic [SEGS-1:0]                       rx_sop,
  input  wire logic [SEGS-1:0]                       rx_eop,
  input  wire logic [SEGS-1:0]                       rx_err,
  input  wire logic [SEGS-1:0][spb_pkg::MTY_W-1:0]   rx_mty,
  // User receive stream
  output logic [SEGS-1:0]                            usr_rx_valid,
  output logic [SEGS-1:0][SEG_W-1:0]                 usr_rx_data,
  output logic [SEGS-1:0]                            usr_rx_sop,
  output logic [SEGS-1:0]                            usr_rx_eop,
  output logic [SEGS-1:0]                            usr_rx_err,
  output logic [SEGS-1:0][spb_pkg::MTY_W-1:0]        usr_rx_mty
);

  // ==========================================================================
  // Elaboration checks
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  if (SEG_W != BYTE_W * (1 << MTY_W)) begin : g_bad_width
    $error("Segment width must match the empty-count width");
  end
  if (SEGS < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Segments must be present and depth a power of two of at least two");
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Beat legality
  // Walks segments in order so packet state carries across segment borders
  function automatic logic [1:0] spb_beat_check(input logic [SEGS-1:0] ena,
                                                input logic [SEGS-1:0] sop,
                                                input logic [SEGS-1:0] eop,
                                                input logic            in_pkt);
    logic ok;
    logic open;
    logic idle_seen;
    ok        = 1'b1;
    open      = in_pkt;
    idle_seen = 1'b0;
    for (int i = 0; i < SEGS; i++) begin
      if (ena[i]) begin
        if (idle_seen) ok = 1'b0;
        if (sop[i] == open) ok = 1'b0;
        open = !eop[i];
      end else begin
        if (open) ok = 1'b0;
        idle_seen = 1'b1;
      end
    end
    return {ok, open};
  endfunction

  // ==========================================================================
  // Two-entry buffer
  // A stall by the device fills this and pulls user ready low, so no beat is lost
  logic [SEGS-1:0][SEG_W-1:0] buf_data [DEPTH];
  logic [4*SEGS-1:0]          buf_flag [DEPTH];
  logic [SEGS-1:0][MTY_W-1:0] buf_mty  [DEPTH];
  logic [PTR_W-1:0]           wr_ptr;
  logic [PTR_W-1:0]           rd_ptr;
  logic [CNT_W-1:0]           count;
  logic [CNT_W-1:0]           next_count;
  logic                       push;
  logic                       pop;
  logic                       head_valid;
  logic [SEGS-1:0]            hd_ena;
  logic [SEGS-1:0]            hd_sop;
  logic [SEGS-1:0]            hd_eop;
  logic [SEGS-1:0]            hd_err;
  logic [1:0]                 check;
  logic                       can_send;
  logic                       issue;
  spb_tx_state_t              state;
  logic                       in_pkt;

  assign push       = usr_tx_valid && usr_tx_ready;
  assign head_valid = (count != '0);
  assign {hd_ena, hd_sop, hd_eop, hd_err} = buf_flag[rd_ptr];
  assign check      = spb_beat_check(hd_ena, hd_sop, hd_eop, in_pkt);
  // Ready is sampled live, so at most one beat lands after it falls
  assign can_send   = head_valid && tx_ready && (state == SPB_RUN);
  assign issue      = can_send && check[1];
  assign pop        = can_send;
  assign next_count = CNT_W'(count + CNT_W'(push) - CNT_W'(pop));

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_data[wr_ptr] <= usr_tx_data;
      buf_flag[wr_ptr] <= {usr_tx_ena, usr_tx_sop, usr_tx_eop, usr_tx_err};
      buf_mty[wr_ptr]  <= usr_tx_mty;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      usr_tx_ready <= 1'b0;
    end else begin
      if (push) wr_ptr <= PTR_W'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= PTR_W'(rd_ptr + 1'b1);
      count        <= next_count;
      usr_tx_ready <= (next_count < CNT_W'(DEPTH));
    end
  end

  // ==========================================================================
  // Overflow halt
  // Recovery needs a core reset, so the halt only clears on sys_rst
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= SPB_RUN;
      usr_tx_halted <= 1'b0;
    end else if (tx_ovf) begin
      state         <= SPB_HALT;
      usr_tx_halted <= 1'b1;
    end
  end

  // ==========================================================================
  // Packet tracking and status pulses
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_pkt      <= 1'b0;
      usr_tx_drop <= 1'b0;
      usr_tx_gap  <= 1'b0;
    end else begin
      if (issue) in_pkt <= check[0];
      usr_tx_drop <= can_send && !check[1];
      // Source starved mid-packet while the device was ready
      usr_tx_gap  <= in_pkt && tx_ready && (state == SPB_RUN) && !head_valid;
    end
  end

  // ==========================================================================
  // Transmit pins, one register set per segment
  for (genvar s = 0; s < SEGS; s++) begin : g_tx
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        tx_ena[s]  <= 1'b0;
        tx_sop[s]  <= 1'b0;
        tx_eop[s]  <= 1'b0;
        tx_err[s]  <= 1'b0;
        tx_mty[s]  <= MTY_NONE;
        tx_data[s] <= '0;
      end else begin
        tx_ena[s]  <= issue && hd_ena[s];
        tx_sop[s]  <= issue && hd_ena[s] && hd_sop[s];
        tx_eop[s]  <= issue && hd_ena[s] && hd_eop[s];
        tx_err[s]  <= issue && hd_ena[s] && hd_eop[s] && hd_err[s];
        // Byte order and full width pass through as the user packed them
        tx_data[s] <= buf_data[rd_ptr][s];
        tx_mty[s]  <= (issue && hd_ena[s] && hd_eop[s]) ? buf_mty[rd_ptr][s] : MTY_NONE;
      end
    end
  end

  // ==========================================================================
  // Receive capture
  // No backpressure exists, so every device beat is registered unconditionally
  function automatic logic [SEG_W-1:0] spb_lane_mask(input logic [MTY_W-1:0] mty);
    logic [SEG_W-1:0] m;
    m = '1;
    for (int b = 0; b < SEG_W / BYTE_W; b++) begin
      if (b < int'(mty)) m[b*BYTE_W +: BYTE_W] = '0;
    end
    return m;
  endfunction

  for (genvar s = 0; s < SEGS; s++) begin : g_rx
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        usr_rx_valid[s] <= 1'b0;
        usr_rx_sop[s]   <= 1'b0;
        usr_rx_eop[s]   <= 1'b0;
        usr_rx_err[s]   <= 1'b0;
        usr_rx_mty[s]   <= MTY_NONE;
        usr_rx_data[s]  <= '0;
      end else begin
        usr_rx_valid[s] <= rx_ena[s];
        usr_rx_sop[s]   <= rx_ena[s] && rx_sop[s];
        usr_rx_eop[s]   <= rx_ena[s] && rx_eop[s];
        usr_rx_err[s]   <= rx_ena[s] && rx_eop[s] && rx_err[s];
        usr_rx_mty[s]   <= (rx_ena[s] && rx_eop[s]) ? rx_mty[s] : MTY_NONE;
        // Empty lanes zeroed so the user never sees stale bytes
        usr_rx_data[s]  <= (rx_ena[s] && rx_eop[s]) ? (rx_data[s] & spb_lane_mask(rx_mty[s]))
                                                    : rx_data[s];
      end
    end
  end

  // ==========================================================================
  // Checks on driven pins
  logic [2:0] bp_writes;
  logic [SEGS-1:0] mty_bad;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bp_writes <= '0;
    end else if (tx_ready) begin
      bp_writes <= '0;
    end else if (tx_ena != '0 && bp_writes != 3'h7) begin
      bp_writes <= 3'(bp_writes + 1'b1);
    end
  end

  for (genvar s = 0; s < SEGS; s++) begin : g_mty
    assign mty_bad[s] = tx_ena[s] && !tx_eop[s] && (tx_mty[s] != MTY_NONE);
  end

  seg0_lead_a: assert property ((tx_ena != '0) |-> tx_ena[0])
    else $error("Data cycle without segment zero");
  seg_contig_a: assert property ((tx_ena != '0) |-> ((tx_ena & (tx_ena + 1'b1)) == '0))
    else $error("Gap between active segments");
  mty_zero_a: assert property (mty_bad == '0)
    else $error("Empty count set outside packet end");
  err_with_eop_a: assert property ((tx_err & ~(tx_ena & tx_eop)) == '0)
    else $error("Error flag without end of packet");
  bp_limit_a: assert property (bp_writes <= 3'(BP_WRITE_LIMIT))
    else $error("Too many writes after ready fell");
  bp_honour_a: assert property (!tx_ready |=> (tx_ena == '0))
    else $error("Write one cycle after ready low");
  halt_stop_a: assert property ((state == SPB_HALT) |=> (tx_ena == '0) [*3])
    else $error("Write after overflow");
  tail_eop_a: assert property (((tx_ena != '0) && !tx_ena[SEGS-1])
                               |-> ((tx_eop & tx_ena & ~(tx_ena >> 1)) != '0))
    else $error("Idle tail segments without end of packet");
  rx_take_a: assert property (rx_ena != '0 |=> usr_rx_valid == $past(rx_ena))
    else $error("Receive beat not taken");
  no_gap_a: assert property ((in_pkt && head_valid && tx_ready && state == SPB_RUN && check[1])
                             |=> (tx_ena != '0))
    else $error("Idle cycle inside packet while ready");

  full_beat_c: cover property (tx_ena == '1);
  short_pkt_c: cover property ((tx_sop & tx_eop) != '0);
  stall_c: cover property (head_valid && !tx_ready ##1 !tx_ready ##1 tx_ready);
  halt_c: cover property ($rose(usr_tx_halted));
  rx_err_c: cover property (usr_rx_err != '0);

endmodule // spb_host

`default_nettype wire

// File: verif/spb_dev_model.sv
// Device-side model of the transmit flow-control pins
`timescale 1ns/1ps
`default_nettype none

module spb_dev_model
  import spb_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  // Transmit pins
  input  wire logic [SEGS-1:0] tx_ena,
  output logic                 tx_ready,
  output logic                 tx_ovf,
  // Bench control
  input  wire logic            stall,
  input  wire logic            ovf_req,
  output var int               late_writes
);
  int after_drop;

  // ==========================================================================
  // Ready, overflow and write counting
  // Only the enables are looked at; data on idle segments is ignored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ready    <= 1'b0;
      tx_ovf      <= 1'b0;
      after_drop  <= 0;
      late_writes <= 0;
    end else begin
      tx_ready <= !stall; // One ready for all segments
      if (tx_ready) begin
        after_drop <= 0;
      end else if (|tx_ena) begin
        after_drop  <= after_drop + 1;
        late_writes <= late_writes + 1;
      end
      // Sticky until reset, so a late recovery attempt still shows
      tx_ovf <= tx_ovf | ovf_req | (!tx_ready && (|tx_ena) && after_drop >= BP_WRITE_LIMIT);
    end
  end

endmodule // spb_dev_model

`default_nettype wire

// File: verif/tb_spb_host.sv
// Self-checking bench for the segmented packet bus host controller
`timescale 1ns/1ps
`default_nettype none

module tb_spb_host;
  import spb_pkg::*;

  typedef struct packed {
    logic [3:0]  ena, sop, eop, err, x_sop, x_eop, x_err;
    logic [15:0] mty, x_mty;
    logic        drop;
  } spb_row_t;

  // ==========================================================================
  // Signals
  logic core_clk, sys_rst, usr_tx_valid, usr_tx_ready, usr_tx_drop, usr_tx_gap, usr_tx_halted;
  logic tx_ready, tx_ovf, stall, ovf_req;
  logic [SEGS-1:0][SEG_W-1:0] usr_tx_data, tx_data, rx_data, usr_rx_data;
  logic [SEGS-1:0] usr_tx_ena, usr_tx_sop, usr_tx_eop, usr_tx_err, tx_ena, tx_sop, tx_eop, tx_err;
  logic [SEGS-1:0] rx_ena, rx_sop, rx_eop, rx_err, usr_rx_valid, usr_rx_sop, usr_rx_eop, usr_rx_err;
  logic [SEGS-1:0][MTY_W-1:0] usr_tx_mty, tx_mty, rx_mty, usr_rx_mty;
  logic [31:0]  c;
  logic [127:0] c_d0;
  int err_count, n_checks, late_writes, i, beats, drops, gaps;

  // Rows: inputs, expected pin framing, dropped
  spb_row_t rows [8] = '{
    {4'hf, 4'h1, 4'h8, 4'h0, 4'h1, 4'h8, 4'h0, 16'h5007, 16'h5000, 1'b0},
    {4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 16'h0000, 16'h0000, 1'b0},
    {4'hf, 4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 16'h0000, 16'h0000, 1'b0},
    {4'hf, 4'h4, 4'h2, 4'h0, 4'h4, 4'h2, 4'h0, 16'h0030, 16'h0030, 1'b0},
    {4'h1, 4'h0, 4'h1, 4'h2, 4'h0, 4'h1, 4'h0, 16'h000f, 16'h000f, 1'b0},
    {4'hb, 4'h1, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 16'h0000, 16'h0000, 1'b1},
    {4'h3, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 16'h0000, 16'h0000, 1'b1},
    {4'h3, 4'h1, 4'h2, 4'h3, 4'h1, 4'h2, 4'h2, 16'h0000, 16'h0000, 1'b0}
  };

  spb_host dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .usr_tx_valid(usr_tx_valid), .usr_tx_ready(usr_tx_ready), .usr_tx_data(usr_tx_data),
    .usr_tx_ena(usr_tx_ena), .usr_tx_sop(usr_tx_sop), .usr_tx_eop(usr_tx_eop),
    .usr_tx_err(usr_tx_err), .usr_tx_mty(usr_tx_mty),
    .usr_tx_drop(usr_tx_drop), .usr_tx_gap(usr_tx_gap), .usr_tx_halted(usr_tx_halted),
    .tx_data(tx_data), .tx_ena(tx_ena), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_err(tx_err),
    .tx_mty(tx_mty), .tx_ready(tx_ready), .tx_ovf(tx_ovf),
    .rx_data(rx_data), .rx_ena(rx_ena), .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_err(rx_err),
    .rx_mty(rx_mty),
    .usr_rx_valid(usr_rx_valid), .usr_rx_data(usr_rx_data), .usr_rx_sop(usr_rx_sop),
    .usr_rx_eop(usr_rx_eop), .usr_rx_err(usr_rx_err), .usr_rx_mty(usr_rx_mty)
  );
  spb_dev_model dev (
    .core_clk(core_clk), .sys_rst(sys_rst), .tx_ena(tx_ena), .tx_ready(tx_ready),
    .tx_ovf(tx_ovf), .stall(stall), .ovf_req(ovf_req), .late_writes(late_writes)
  );

  always #2 core_clk = ~core_clk;

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Waits with valid low until ready is high, then presents the beat for one edge; valid stays up so beats can run back to back
  task automatic send(input spb_row_t r, input logic [7:0] b);
    for (i = 0; i < 20 && usr_tx_ready !== 1'b1; i++) begin
      usr_tx_valid = 1'b0;
      tick(1);
    end
    usr_tx_valid = 1'b1;
    usr_tx_ena = r.ena;
    usr_tx_sop = r.sop;
    usr_tx_eop = r.eop;
    usr_tx_err = r.err;
    usr_tx_mty = r.mty;
    for (int s = 0; s < SEGS; s++) usr_tx_data[s] = {16{b + 8'(s)}};
    tick(1);
  endtask

  // Pins stand one cycle, so every cycle is inspected
  task automatic watch(input int n);
    usr_tx_valid = 1'b0;
    beats = 0;
    drops = 0;
    gaps = 0;
    c = '0;
    repeat (n) begin
      tick(1);
      if (usr_tx_drop === 1'b1) drops++;
      if (usr_tx_gap === 1'b1) gaps++;
      if (tx_ena !== 4'h0) begin
        beats++;
        c = {tx_ena, tx_sop, tx_eop, tx_err, tx_mty};
        c_d0 = tx_data[0];
      end
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end

  // ==========================================================================
  // Sequence
  initial begin
    {core_clk, usr_tx_valid, stall, ovf_req, usr_tx_ena, usr_tx_sop, usr_tx_eop, usr_tx_err} = '0;
    {usr_tx_mty, usr_tx_data, rx_ena, rx_sop, rx_eop, rx_err, rx_mty, rx_data} = '0;
    {err_count, n_checks} = '0;
    sys_rst = 1'b1;
    tick(4);
    check("ready in reset", 0, usr_tx_ready);
    check("pins in reset", 0, {tx_ena, usr_rx_valid});
    tick(4);
    sys_rst = 1'b0;
    tick(2);
    check("ready after reset", 1, usr_tx_ready);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      send(rows[k], 8'(k * 16));
      watch(8);
      check("drop pulse", 128'(rows[k].drop), 128'(drops));
      check("beat", rows[k].drop ? 32'h0 : {rows[k].ena, rows[k].x_sop, rows[k].x_eop, rows[k].x_err, rows[k].x_mty}, c);
      if (!rows[k].drop) check("seg0 data", {16{8'(k * 16)}}, c_d0);
      $display("row %0d done", k);
    end
    // Stall: buffer fills, nothing leaves while ready is low
    stall = 1'b1;
    tick(3);
    send(rows[2], 8'h20);
    send(rows[4], 8'h40);
    usr_tx_valid = 1'b0;
    tick(1);
    check("ready when full", 0, usr_tx_ready);
    watch(6);
    check("beats while stalled", 0, 128'(beats));
    check("writes while low", 0, 128'(late_writes));
    stall = 1'b0;
    watch(8);
    check("beats after stall", 2, 128'(beats));
    $display("stall test done");
    // Open packet with an empty buffer reports a gap
    send(rows[2], 8'h20);
    watch(6);
    check("gap seen", 1, gaps > 0);
    send(rows[4], 8'h40);
    watch(6);
    $display("gap test done");
    // Overflow halts transmit until reset
    ovf_req = 1'b1;
    tick(2);
    check("halted", 1, usr_tx_halted);
    send(rows[1], 8'h10);
    watch(6);
    check("beats when halted", 0, 128'(beats));
    sys_rst = 1'b1;
    ovf_req = 1'b0;
    tick(2);
    sys_rst = 1'b0;
    tick(2);
    check("halt cleared", 2'b01, {usr_tx_halted, usr_tx_ready});
    $display("overflow test done");
    // Receive: two-segment frame, then an errored single segment
    rx_ena = 4'h3;
    rx_sop = 4'h1;
    rx_eop = 4'h2;
    rx_mty = 16'h0020;
    rx_data = {64{8'ha5}};
    tick(1);
    check("rx frame", {4'h3, 4'h1, 4'h2, 4'h0, 16'h0020}, {usr_rx_valid, usr_rx_sop, usr_rx_eop, usr_rx_err, usr_rx_mty});
    check("rx lanes", 32'ha5a50000, {usr_rx_data[1][127:112], usr_rx_data[1][15:0]});
    {rx_ena, rx_sop, rx_eop, rx_err} = 16'h1111;
    rx_mty = 16'h0008;
    tick(1);
    {rx_ena, rx_sop, rx_eop, rx_err} = '0;
    rx_data = ~rx_data;
    check("rx error", {4'h1, 4'h1, 4'h1, 16'h0008}, {usr_rx_valid, usr_rx_eop, usr_rx_err, usr_rx_mty});
    tick(1);
    check("rx idle", 0, usr_rx_valid);
    $display("receive test done");
    tally_and_finish;
  end

endmodule // tb_spb_host

`default_nettype wire
